/* File: hw/adcs_pkg.sv */
// constants, types and register map for the conversion sequencer
package adcs_pkg;
	localparam int ADCS_CLK_HZ = 10_000_000;
	localparam int ADCS_CLK_NS = 1_000_000_000 / ADCS_CLK_HZ;
	localparam int ADCS_INSTR_CYC = 4;
	localparam int ADCS_RC_TAD_NS = 4000;
	localparam int ADCS_RC_HALF = ADCS_RC_TAD_NS / (2 * ADCS_CLK_NS);
	localparam int ADCS_HALF_2 = 1;
	localparam int ADCS_HALF_8 = 4;
	localparam int ADCS_HALF_32 = 16;
	localparam int ADCS_CONV_HALVES = 19;
	localparam int ADCS_RECOV_HALVES = 4;
	localparam logic [7:0] ADCS_OFS_CTRL = 8'h00;
	localparam logic [7:0] ADCS_OFS_PCFG = 8'h04;
	localparam logic [7:0] ADCS_OFS_RESULT = 8'h08;
	localparam logic [7:0] ADCS_OFS_IRQFLAG = 8'h0C;
	localparam logic [7:0] ADCS_OFS_IRQEN = 8'h10;
	localparam logic [7:0] ADCS_OFS_PORT = 8'h14;
	localparam int ADCS_BIT_ON = 0;
	localparam int ADCS_BIT_GO = 2;
	localparam int ADCS_CHS_LO = 3;
	localparam int ADCS_CLK_LO = 6;
	localparam int ADCS_BIT_IRQ = 6;
	localparam logic [2:0] ADCS_RST_PCFG = 3'h0;
	localparam logic [1:0] ADCS_CLK_RC = 2'h3;
	localparam logic [7:0] ADCS_MSB = 8'h80;
	typedef enum logic [2:0] {ST_OFF, ST_ACQ, ST_STARTDLY, ST_CONV, ST_RECOV} adcs_state_t;
	typedef struct packed {
		logic [7:0] trial;
		logic holdConnect;
		logic converting;
		logic analogOn;
		logic [1:0] channel;
	} adcs_cmp_t;
endpackage

/* File: hw/adc_conversion_sequencer.sv */
// conversion sequencer with APB register slave
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module adc_conversion_sequencer
	import adcs_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleepMode,
	input wire logic cmpDecision,
	input wire logic [3:0] pinLevel,
	input wire logic [3:0] pinDriveEn,
	output logic wakeRequest,
	output adcs_cmp_t cmpBus
);
	adcs_state_t state_q;
	logic [1:0] clkSel_q;
	logic [1:0] chan_q;
	logic on_q;
	logic go_q;
	logic [2:0] pcfg_q;
	logic irqFlag_q;
	logic irqEn_q;
	logic pwrDown_q;
	logic [7:0] result_q;
	logic [7:0] sar_q;
	logic [7:0] mask_q;
	logic [4:0] divCnt_q;
	logic [4:0] halfCnt_q;
	logic [2:0] instrCnt_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic wake_q;
	adcs_cmp_t cmp_q;
	logic apbDo;
	logic wrEn;
	logic mapped;
	logic ctrlWr;
	logic [31:0] readVal;
	logic [4:0] halfLen;
	logic halfTick;
	logic running;
	logic sleepAbort;
	logic abortNow;
	logic startNow;
	logic decideNow;
	logic convDone;
	logic recovDone;
	logic selDriven;
	logic decision;
	logic [3:0] analogMask;

	// apb access and decode
	assign apbDo = psel && penable && pready_q;
	assign wrEn = apbDo && pwrite;
	assign ctrlWr = wrEn && (paddr == ADCS_OFS_CTRL);
	assign mapped = (paddr == ADCS_OFS_CTRL) || (paddr == ADCS_OFS_PCFG) || (paddr == ADCS_OFS_RESULT)
		|| (paddr == ADCS_OFS_IRQFLAG) || (paddr == ADCS_OFS_IRQEN) || (paddr == ADCS_OFS_PORT);

	// analog pins per port config, bit order ch3..ch0
	always_comb begin
		case (pcfg_q)
			3'h0: analogMask = 4'hF;
			3'h1: analogMask = 4'hF;
			3'h2: analogMask = 4'h7;
			3'h3: analogMask = 4'h7;
			3'h4: analogMask = 4'h3;
			3'h5: analogMask = 4'h3;
			3'h6: analogMask = 4'h1;
			default: analogMask = 4'h0;
		endcase
	end

	// read mux
	always_comb begin
		readVal = 32'h0;
		case (paddr)
			ADCS_OFS_CTRL: begin
				readVal[ADCS_CLK_LO +: 2] = clkSel_q;
				readVal[ADCS_CHS_LO +: 2] = chan_q;
				readVal[ADCS_BIT_GO] = go_q;
				readVal[ADCS_BIT_ON] = on_q;
			end
			ADCS_OFS_PCFG: readVal[2:0] = pcfg_q;
			ADCS_OFS_RESULT: readVal[7:0] = result_q;
			ADCS_OFS_IRQFLAG: readVal[ADCS_BIT_IRQ] = irqFlag_q;
			ADCS_OFS_IRQEN: readVal[ADCS_BIT_IRQ] = irqEn_q;
			ADCS_OFS_PORT: readVal[3:0] = pinLevel & ~analogMask;
			default: readVal = 32'h0;
		endcase
	end

	// apb handshake, one wait state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !mapped;
			if (psel && penable && !pready_q) begin
				prdata_q <= pwrite ? 32'h0 : readVal;
			end
		end
	end

	// bit period divider in half periods
	always_comb begin
		case (clkSel_q)
			2'h0: halfLen = 5'(ADCS_HALF_2);
			2'h1: halfLen = 5'(ADCS_HALF_8);
			2'h2: halfLen = 5'(ADCS_HALF_32);
			default: halfLen = 5'(ADCS_RC_HALF);
		endcase
	end
	assign running = (state_q == ST_CONV) || (state_q == ST_RECOV);
	assign halfTick = running && (divCnt_q >= halfLen - 5'h1); // a clock select change mid-count cannot wrap the divider

	// sequencing events
	assign sleepAbort = sleepMode && (clkSel_q != ADCS_CLK_RC)
		&& ((state_q == ST_CONV) || (state_q == ST_STARTDLY));
	assign abortNow = ((state_q == ST_CONV) || (state_q == ST_STARTDLY))
		&& (!go_q || sleepAbort);
	assign startNow = (state_q == ST_ACQ) && go_q && !pwrDown_q;
	assign decideNow = (state_q == ST_CONV) && halfTick && halfCnt_q[0] && (halfCnt_q < 5'h10);
	assign convDone = (state_q == ST_CONV) && halfTick && !abortNow
		&& (halfCnt_q == 5'(ADCS_CONV_HALVES - 1));
	assign recovDone = (state_q == ST_RECOV) && halfTick
		&& (halfCnt_q == 5'(ADCS_RECOV_HALVES - 1));
	assign selDriven = pinDriveEn[chan_q];
	assign decision = selDriven ? pinLevel[chan_q] : cmpDecision;

	// main state machine
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_OFF;
		end else if (!on_q) begin
			state_q <= ST_OFF;
		end else begin
			case (state_q)
				ST_OFF: state_q <= ST_ACQ;
				ST_ACQ: begin
					if (startNow) begin
						state_q <= (clkSel_q == ADCS_CLK_RC) ? ST_STARTDLY : ST_CONV;
					end
				end
				ST_STARTDLY: begin
					if (abortNow) begin
						state_q <= ST_RECOV;
					end else if (instrCnt_q == 3'(ADCS_INSTR_CYC - 1)) begin
						state_q <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (abortNow || convDone) begin
						state_q <= ST_RECOV;
					end
				end
				ST_RECOV: begin
					if (recovDone) begin
						state_q <= ST_ACQ;
					end
				end
				default: state_q <= ST_OFF;
			endcase
		end
	end

	// divider and period counters
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			divCnt_q <= 5'h0;
			halfCnt_q <= 5'h0;
			instrCnt_q <= 3'h0;
		end else begin
			instrCnt_q <= (state_q == ST_STARTDLY) ? instrCnt_q + 3'h1 : 3'h0;
			if (!running || abortNow || convDone) begin
				divCnt_q <= 5'h0;
				halfCnt_q <= 5'h0;
			end else if (halfTick) begin
				divCnt_q <= 5'h0;
				halfCnt_q <= halfCnt_q + 5'h1;
			end else begin
				divCnt_q <= divCnt_q + 5'h1;
			end
		end
	end

	// successive approximation register, msb first
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sar_q <= 8'h0;
			mask_q <= ADCS_MSB;
		end else if (state_q != ST_CONV) begin
			sar_q <= 8'h0;
			mask_q <= ADCS_MSB;
		end else if (decideNow) begin
			sar_q <= decision ? (sar_q | mask_q) : sar_q;
			mask_q <= mask_q >> 1;
		end
	end

	// control fields
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			clkSel_q <= 2'h0;
			chan_q <= 2'h0;
			on_q <= 1'b0;
			pcfg_q <= ADCS_RST_PCFG;
			irqEn_q <= 1'b0;
		end else begin
			if (ctrlWr) begin
				clkSel_q <= pwdata[ADCS_CLK_LO +: 2];
				chan_q <= pwdata[ADCS_CHS_LO +: 2];
				on_q <= pwdata[ADCS_BIT_ON];
			end
			if (wrEn && (paddr == ADCS_OFS_PCFG)) begin
				pcfg_q <= pwdata[2:0];
			end
			if (wrEn && (paddr == ADCS_OFS_IRQEN)) begin
				irqEn_q <= pwdata[ADCS_BIT_IRQ];
			end
		end
	end

	// go flag: software set wins over hardware clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			go_q <= 1'b0;
		end else if (ctrlWr && pwdata[ADCS_BIT_GO] && pwdata[ADCS_BIT_ON] && on_q) begin
			go_q <= 1'b1;
		end else if (ctrlWr) begin
			go_q <= 1'b0;
		end else if (convDone || sleepAbort || !on_q) begin
			go_q <= 1'b0;
		end
	end

	// interrupt flag: completion wins over software clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqFlag_q <= 1'b0;
		end else if (convDone) begin
			irqFlag_q <= 1'b1;
		end else if (wrEn && (paddr == ADCS_OFS_IRQFLAG)) begin
			irqFlag_q <= pwdata[ADCS_BIT_IRQ];
		end
	end

	// result holds across reset and aborts
	always_ff @(posedge clk) begin
		if (convDone) begin
			result_q <= sar_q;
		end else if (wrEn && (paddr == ADCS_OFS_RESULT)) begin
			result_q <= pwdata[7:0];
		end
	end

	// sleep power-down and wake
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pwrDown_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			wake_q <= convDone && sleepMode && irqEn_q;
			if (sleepAbort || (convDone && sleepMode && !irqEn_q)) begin
				pwrDown_q <= 1'b1;
			end else if (!sleepMode) begin
				pwrDown_q <= 1'b0;
			end
		end
	end

	// analog side outputs, registered
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp_q <= '0;
		end else begin
			cmp_q.trial <= sar_q | mask_q;
			cmp_q.holdConnect <= (state_q == ST_ACQ) && on_q && !pwrDown_q;
			cmp_q.converting <= (state_q == ST_CONV) && !abortNow;
			cmp_q.analogOn <= on_q && !pwrDown_q;
			cmp_q.channel <= chan_q;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign wakeRequest = wake_q;
	assign cmpBus = cmp_q;
endmodule

/* File: tb/adcs_monitor.sv */
// port checker for the conversion sequencer
`timescale 1ns/1ps
module adcs_monitor
	import adcs_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sleepMode,
	input wire logic cmpDecision,
	input wire logic [3:0] pinLevel,
	input wire logic [3:0] pinDriveEn,
	input wire logic wakeRequest,
	input wire adcs_cmp_t cmpBus
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// first access cycle of a transfer
	sequence s_access;
		psel && penable && !$past(penable);
	endsequence
	// answer comes one cycle after the first access cycle
	sequence s_one_wait;
		!pready ##1 pready;
	endsequence
	a_ready_wait: assert property (s_access |-> s_one_wait)
		else $error("pready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("pslverr without pready or with data");
	a_recov_gap: assert property ($fell(cmpBus.converting) |-> !cmpBus.holdConnect [*4])
		else $error("hold connected too soon after conversion");
	a_off_idle: assert property (!cmpBus.analogOn |-> !cmpBus.converting)
		else $error("converting while converter off");
	a_wake_cause: assert property (wakeRequest |-> sleepMode && cmpBus.analogOn)
		else $error("wake request outside sleep");
	a_wake_pulse: assert property (wakeRequest |=> !wakeRequest)
		else $error("wake request longer than one cycle");
	a_trial_msb: assert property ($rose(cmpBus.converting) |-> cmpBus.trial == ADCS_MSB)
		else $error("first trial is not msb");
endmodule

/* File: tb/adcs_cmp_model.sv */
// comparator model answering the sequencer trials
`timescale 1ns/1ps
module adcs_cmp_model
	import adcs_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire adcs_cmp_t cmpBus,
	input wire logic [7:0] level,
	output logic decision
);
	logic idle_q;
	// toggling answer while no trial is applied
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			idle_q <= 1'b0;
		end else begin
			idle_q <= ~idle_q;
		end
	end
	// input at or above the trial code answers one
	assign decision = (cmpBus.trial != 8'h00) ? (level >= cmpBus.trial) : idle_q;
endmodule

/* File: tb/test_adc_conversion_sequencer.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module test_adc_conversion_sequencer
	import adcs_pkg::*;
;
	logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic sleepMode = 1'b0, cmpDecision, wakeRequest;
	logic [7:0] paddr = 8'h00, level = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pinLevel = 4'h0, pinDriveEn = 4'h0;
	adcs_cmp_t cmpBus;
	int errorCnt = 0, nCompared = 0, m0 = 0;
	// clock
	initial begin
		forever #50 clk = ~clk;
	end
	adc_conversion_sequencer DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleepMode(sleepMode), .cmpDecision(cmpDecision), .pinLevel(pinLevel), .pinDriveEn(pinDriveEn),
		.wakeRequest(wakeRequest), .cmpBus(cmpBus));
	adcs_cmp_model uCmp (.clk(clk), .arst_n(arst_n), .cmpBus(cmpBus), .level(level), .decision(cmpDecision));
	task automatic wrapUp;
		if (errorCnt == 0 && nCompared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		nCompared++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			errorCnt++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	// power on, wait until the channel is being acquired, then start
	task automatic start(input logic [7:0] c);
		int k;
		k = 0;
		apb(1'b1, ADCS_OFS_CTRL, {24'h0, c});
		while (cmpBus.holdConnect !== 1'b1 && k < 200) begin
			@(posedge clk);
			k++;
		end
		tick(10);
		apb(1'b1, ADCS_OFS_CTRL, {24'h0, c | 8'h04});
	endtask
	task automatic t_conv(input logic [1:0] sel, input int h, input logic [1:0] ch, input logic [7:0] e);
		int n, m;
		n = 0;
		m = 0;
		start({sel, 1'b0, ch, 3'h1});
		repeat (500) begin
			@(posedge clk);
			if (cmpBus.converting === 1'b1) n++;
			else if (n > 0) break;
			else m++;
		end
		chk("conv cycles", 19 * h, n);
		if (sel == 2'h0) m0 = m;
		if (sel == 2'h3) chk("rc start", m0 + ADCS_INSTR_CYC, m);
		chk("channel", {30'h0, ch}, {30'h0, cmpBus.channel});
		rdc("ctrl", ADCS_OFS_CTRL, {24'h0, sel, 1'b0, ch, 3'h1});
		rdc("result", ADCS_OFS_RESULT, {24'h0, e});
		rdc("irq flag", ADCS_OFS_IRQFLAG, 32'h40);
		apb(1'b1, ADCS_OFS_IRQFLAG, 32'h0);
	endtask
	task automatic t_abort;
		int n;
		n = 0;
		apb(1'b1, ADCS_OFS_RESULT, 32'h5A);
		start(8'h41);
		tick(20);
		apb(1'b1, ADCS_OFS_CTRL, 32'h41);
		while (cmpBus.holdConnect !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk("abort gap", 1'b1, n >= 15 && n <= 20);
		rdc("result kept", ADCS_OFS_RESULT, 32'h5A);
		rdc("no irq", ADCS_OFS_IRQFLAG, 32'h0);
	endtask
	task automatic t_port;
		logic [3:0] dig [8] = '{4'h0, 4'h0, 4'h8, 4'h8, 4'hC, 4'hC, 4'hE, 4'hF};
		pinLevel <= 4'hF;
		for (int p = 0; p < 8; p++) begin
			apb(1'b1, ADCS_OFS_PCFG, p);
			rdc("port", ADCS_OFS_PORT, {28'h0, dig[p]});
		end
		apb(1'b1, ADCS_OFS_PCFG, 32'h0);
	endtask
	task automatic t_sleep_rc(input logic en);
		int w;
		w = 0;
		apb(1'b1, ADCS_OFS_IRQEN, {25'h0, en, 6'h0});
		start(8'hC1);
		sleepMode <= 1'b1;
		repeat (600) begin
			@(posedge clk);
			if (wakeRequest === 1'b1) w++;
		end
		chk("wake", en, w);
		chk("analog on", en, cmpBus.analogOn);
		rdc("power bit", ADCS_OFS_CTRL, 32'hC1);
		sleepMode <= 1'b0;
	endtask
	task automatic t_sleep_osc;
		start(8'h01);
		tick(3);
		sleepMode <= 1'b1;
		tick(5);
		chk("aborted", 1'b0, cmpBus.converting);
		chk("powered down", 1'b0, cmpBus.analogOn);
		rdc("power kept", ADCS_OFS_CTRL, 32'h01);
		sleepMode <= 1'b0;
		tick(8);
	endtask
	task automatic t_reset_mid;
		apb(1'b1, ADCS_OFS_RESULT, 32'h77);
		start(8'h41);
		tick(10);
		arst_n <= 1'b0;
		tick(2);
		arst_n <= 1'b1;
		rdc("ctrl off", ADCS_OFS_CTRL, 32'h0);
		rdc("result kept", ADCS_OFS_RESULT, 32'h77);
		chk("off after reset", 1'b0, cmpBus.analogOn);
	endtask
	// watchdog
	initial begin
		tick(20000);
		errorCnt++;
		wrapUp;
	end
	// main sequence
	initial begin
		tick(5);
		arst_n <= 1'b1;
		rdc("ctrl reset", ADCS_OFS_CTRL, 32'h0);
		rdc("pcfg reset", ADCS_OFS_PCFG, 32'h0);
		rdc("unmapped", 8'h18, 32'h0);
		chk("slverr", 1'b1, err);
		level <= 8'hA5;
		t_conv(2'h0, 1, 2'h0, 8'hA5);
		level <= 8'h3C;
		t_conv(2'h1, 4, 2'h1, 8'h3C);
		level <= 8'h01;
		t_conv(2'h2, 16, 2'h3, 8'h01);
		level <= 8'hFE;
		t_conv(2'h3, 20, 2'h2, 8'hFE);
		level <= 8'h10;
		pinDriveEn <= 4'hF;
		for (int c = 0; c < 4; c++) begin
			pinLevel <= 4'h1 << c;
			t_conv(2'h0, 1, c[1:0], 8'hFF);
		end
		pinDriveEn <= 4'h0;
		t_abort;
		t_port;
		t_sleep_rc(1'b1);
		t_sleep_rc(1'b0);
		t_sleep_osc;
		t_reset_mid;
		wrapUp;
	end
endmodule
bind adc_conversion_sequencer adcs_monitor uMon (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sleepMode(sleepMode), .cmpDecision(cmpDecision), .pinLevel(pinLevel), .pinDriveEn(pinDriveEn),
	.wakeRequest(wakeRequest), .cmpBus(cmpBus));
